// [logic/dbc_pkg.sv]
`default_nettype none
package dbc_pkg;
  localparam logic [2:0] DBC_ADDR_MEMCTL = 3'h2;
  localparam logic [2:0] DBC_ADDR_EXTIO = 3'h3;
  localparam logic [2:0] DBC_ADDR_CODEC = 3'h4;
  localparam int DBC_IO_AW = 3;
  localparam int DBC_DW = 8;
  localparam int DBC_LINES = 4;
  localparam int DBC_PAGE_W = 5;
  localparam int DBC_DSP_AW = 16;
  localparam int DBC_EXT_AW = 20;
  localparam int DBC_WIN_BIT = 15;
  localparam logic [7:0] DBC_MEMCTL_RST = 8'h80;
  localparam logic [7:0] DBC_EXTIO_RST = 8'h30;
  localparam logic [7:0] DBC_CODEC_RST = 8'h06;
  localparam logic [7:0] DBC_CODEC_WMASK = 8'hdf;
  localparam int DBC_MEM_BANK_B = 7;
  localparam int DBC_MEM_WIDE_B = 6;
  localparam int DBC_MEM_ODD_B = 5;
  localparam int DBC_CC_CLK_B = 7;
  localparam int DBC_CC_PWR_B = 6;
  localparam int DBC_CC_LEFT_B = 4;
  localparam int DBC_CC_RIGHT_B = 3;
  localparam int DBC_CC_DEM_HI_B = 2;
  localparam int DBC_CC_DEM_LO_B = 1;
  localparam int DBC_CC_SPEED_B = 0;

  typedef enum logic [0:0] {
    DBC_HALF_LO = 1'b0,
    DBC_HALF_HI = 1'b1
  } dbc_half_t;

  typedef struct packed {
    logic memory_bank_select;
    logic wide_access_select;
    logic odd_word_align;
    logic [DBC_PAGE_W-1:0] page_select;
  } dbc_memctl_t;

  typedef struct packed {
    logic codec_clock_gate;
    logic codec_power_enable;
    logic left_input_select;
    logic right_input_select;
    logic [1:0] deemphasis_select;
    logic sample_speed_mode;
  } dbc_codec_t;
endpackage : dbc_pkg
`default_nettype wire

// [logic/dbc_io_line.sv]
`default_nettype none
module dbc_io_line
  import dbc_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic dir,
  input wire logic level,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  output logic rd_level_q
);
  assign pin_oe = dir;
  assign pin_o = level;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_level_q <= 1'b0;
    end else begin
      rd_level_q <= dir ? level : pin_i;
    end
  end

  line_release_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !dir |=> (rd_level_q == $past(pin_i))) else $error("Input line not read back");
endmodule : dbc_io_line
`default_nettype wire

// [logic/dbc_regs.sv]
// Notes on behaviour
// - I/O addresses 2, 3, 4 select memory, line and codec control registers.
// - Memory bit 7 picks onboard (0) or daughterboard (1) memory; resets 1.
// - Memory bit 6 picks 16-bit (0) or 32-bit (1) daughterboard access; resets 0.
// - Memory bit 5 marks even or odd 32-bit access, timing selects; resets 0.
// - Memory bits 4:0 select one of 32 pages of 32K words; reset page 0.
// - External data memory responds only in window 0x8000 to 0xffff.
// - Address bits 14:0 pass through; bits 19:15 come from the page bits.
// - Line register bits 7:4 set line directions; reset lines 3,2 in, 1,0 out.
// - Line register bits 3:0 set output levels and read live levels; reset low.
// - Codec bit 7 gates the codec clocks; resets 0.
// - Codec bit 6 drives codec power-down input; 0 powered down; resets 0.
// - Codec bits 4 and 3 pick left and right input; 0 line, 1 microphone.
// - Codec bits 2:1 pick de-emphasis 32k, 44.1k, 48k or off; resets 11.
// - Codec bit 0 picks speed mode; 0 up to 48 kHz; resets 0.
// - Codec bit 5 ignores writes and reads zero.
`default_nettype none
module dbc_regs
  import dbc_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [DBC_IO_AW-1:0] io_addr,
  input wire logic io_sel,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [DBC_DW-1:0] io_wdata,
  output logic [DBC_DW-1:0] io_rdata,
  input wire logic [DBC_DSP_AW-1:0] dsp_addr,
  input wire logic data_strobe,
  input wire logic io_space_strobe,
  output logic onboard_mem_sel,
  output logic board_mem_sel,
  output logic board_io_sel,
  output logic [DBC_EXT_AW-1:0] ext_addr,
  output logic wide_access_select,
  output logic odd_word_align,
  output logic board_half_sel,
  input wire logic [DBC_LINES-1:0] ext_line_i,
  output logic [DBC_LINES-1:0] ext_line_o,
  output logic [DBC_LINES-1:0] ext_line_oe,
  output logic codec_clock_gate,
  output logic codec_power_enable,
  output logic left_input_select,
  output logic right_input_select,
  output logic [1:0] deemphasis_select,
  output logic sample_speed_mode
);
  dbc_memctl_t memory_control_reg_q;
  logic [DBC_DW-1:0] ext_io_reg_q;
  dbc_codec_t codec_control_reg_q;
  logic [DBC_LINES-1:0] line_rd;
  logic in_window;
  dbc_half_t half_q;
  logic [DBC_DW-1:0] rdata_d;

  wire wr_mem = io_sel && io_wr && (io_addr == DBC_ADDR_MEMCTL);
  wire wr_ext = io_sel && io_wr && (io_addr == DBC_ADDR_EXTIO);
  wire wr_cc = io_sel && io_wr && (io_addr == DBC_ADDR_CODEC);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      memory_control_reg_q <= dbc_memctl_t'(DBC_MEMCTL_RST);
    end else if (wr_mem) begin
      memory_control_reg_q <= dbc_memctl_t'(io_wdata);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ext_io_reg_q <= DBC_EXTIO_RST;
    end else if (wr_ext) begin
      ext_io_reg_q <= io_wdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      codec_control_reg_q <= dbc_codec_t'(DBC_CODEC_RST[6:0]);
    end else if (wr_cc) begin
      codec_control_reg_q <= dbc_codec_t'({io_wdata[7:6], io_wdata[4:0]});
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DBC_LINES; gi++) begin : g_line
      dbc_io_line u_line (
        .mclk(mclk),
        .arst_n(arst_n),
        .dir(ext_io_reg_q[DBC_LINES + gi]),
        .level(ext_io_reg_q[gi]),
        .pin_i(ext_line_i[gi]),
        .pin_o(ext_line_o[gi]),
        .pin_oe(ext_line_oe[gi]),
        .rd_level_q(line_rd[gi])
      );
    end
  endgenerate

  always_comb begin
    rdata_d = '0;
    case (io_addr)
      DBC_ADDR_MEMCTL: rdata_d = memory_control_reg_q;
      DBC_ADDR_EXTIO: rdata_d = {ext_io_reg_q[7:4], line_rd};
      DBC_ADDR_CODEC: rdata_d = {codec_control_reg_q[6:5], 1'b0,
                                 codec_control_reg_q[4:0]};
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      io_rdata <= '0;
    end else if (io_sel && io_rd) begin
      io_rdata <= rdata_d;
    end
  end

  assign in_window = dsp_addr[DBC_WIN_BIT];
  assign onboard_mem_sel = data_strobe && in_window && !memory_control_reg_q.memory_bank_select;
  assign board_mem_sel = data_strobe && in_window && memory_control_reg_q.memory_bank_select;
  assign board_io_sel = io_space_strobe && in_window;
  assign ext_addr = {memory_control_reg_q.page_select, dsp_addr[DBC_WIN_BIT-1:0]};
  assign wide_access_select = memory_control_reg_q.wide_access_select;
  assign odd_word_align = memory_control_reg_q.odd_word_align;

  // half tracking: second access of a pair is at the base address
  // whose parity the odd bit gives; low address bit then says which half.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      half_q <= DBC_HALF_LO;
    end else if (board_mem_sel || board_io_sel) begin
      half_q <= dbc_half_t'(dsp_addr[0] ^ memory_control_reg_q.odd_word_align);
    end
  end
  assign board_half_sel = memory_control_reg_q.wide_access_select && (half_q == DBC_HALF_HI);

  assign codec_clock_gate = codec_control_reg_q.codec_clock_gate;
  assign codec_power_enable = codec_control_reg_q.codec_power_enable;
  assign left_input_select = codec_control_reg_q.left_input_select;
  assign right_input_select = codec_control_reg_q.right_input_select;
  assign deemphasis_select = codec_control_reg_q.deemphasis_select;
  assign sample_speed_mode = codec_control_reg_q.sample_speed_mode;

  memctl_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_mem |=> (memory_control_reg_q == $past(io_wdata))) else $error("Memory write lost");
  codec_rsvd_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (io_sel && io_rd && io_addr == DBC_ADDR_CODEC) |=> !io_rdata[5])
    else $error("Reserved bit reads one");
  window_gate_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !dsp_addr[DBC_WIN_BIT] |-> !(onboard_mem_sel || board_mem_sel || board_io_sel))
    else $error("Select outside window");
  addr_ext_a: assert property (@(posedge mclk) disable iff (!arst_n)
    ext_addr[19:15] == memory_control_reg_q.page_select) else $error("Page bits wrong");
  line_dir_a: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_ext |=> (ext_line_oe == $past(io_wdata[7:4]))) else $error("Direction not applied");
  line_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (ext_line_oe == 4'h0 && $past(ext_line_oe) == 4'h0 && io_sel && io_rd &&
     io_addr == DBC_ADDR_EXTIO)
    |=> io_rdata[3:0] == $past(ext_line_i, 2)) else $error("Line level misread");
  codec_gate_a: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_cc |=> codec_clock_gate == $past(io_wdata[7]) && codec_power_enable == $past(io_wdata[6]))
    else $error("Codec gate not applied");
  deemph_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !wr_cc |=> $stable(deemphasis_select)) else $error("De-emphasis changed");
  unmapped_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (io_sel && io_rd && io_addr > DBC_ADDR_CODEC) |=> io_rdata == 8'h00)
    else $error("Unmapped read nonzero");

  cov_wide_c: cover property (@(posedge mclk) disable iff (!arst_n)
    wide_access_select && board_mem_sel);
  cov_codec_c: cover property (@(posedge mclk) disable iff (!arst_n)
    codec_clock_gate ##[1:20] codec_power_enable);
  cov_onboard_c: cover property (@(posedge mclk) disable iff (!arst_n) onboard_mem_sel);
endmodule : dbc_regs
`default_nettype wire

// [tb/dbc_dsp_model.sv]
`default_nettype none
module dbc_dsp_model
  import dbc_pkg::*;
(
  input wire logic mclk,
  output logic [DBC_IO_AW-1:0] io_addr,
  output logic io_sel,
  output logic io_wr,
  output logic io_rd,
  output logic [DBC_DW-1:0] io_wdata,
  input wire logic [DBC_DW-1:0] io_rdata,
  output logic [DBC_DSP_AW-1:0] dsp_addr,
  output logic data_strobe,
  output logic io_space_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {io_sel, io_wr, io_rd, io_addr, io_wdata} = '0;
    {dsp_addr, data_strobe, io_space_strobe} = '0;
  end
  // Released data lines show the inverse, never the stale value
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    {io_sel, io_wr, io_addr, io_wdata} <= {2'b11, a, d};
    @(negedge mclk);
    {io_sel, io_wr, io_wdata} <= {2'b00, ~d};
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge mclk);
    {io_sel, io_rd, io_addr} <= {2'b11, a};
    @(negedge mclk);
    {io_sel, io_rd} <= 2'b00;
    d = io_rdata;
  endtask : rd
  task automatic acc(input logic [15:0] a, input logic ds, input logic ios);
    @(negedge mclk);
    {dsp_addr, data_strobe, io_space_strobe} <= {a, ds, ios};
    @(negedge mclk);
  endtask : acc
endmodule : dbc_dsp_model
`default_nettype wire

// [tb/testbench.sv]
`default_nettype none
module testbench import dbc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] ext_drv = 4'ha;
  logic [2:0] io_addr;
  logic io_sel, io_wr, io_rd, data_strobe, io_space_strobe;
  logic [7:0] io_wdata, io_rdata;
  logic [15:0] dsp_addr;
  logic onboard_mem_sel, board_mem_sel, board_io_sel, wide_access_select, odd_word_align;
  logic board_half_sel, codec_clock_gate, codec_power_enable, left_input_select;
  logic right_input_select, sample_speed_mode;
  logic [1:0] deemphasis_select;
  logic [19:0] ext_addr;
  logic [3:0] ext_line_i, ext_line_o, ext_line_oe;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Daughterboard side drives only lines the block has released
  assign ext_line_i = (ext_line_oe & ext_line_o) | (~ext_line_oe & ext_drv);
  dbc_regs u_dut (.mclk, .arst_n, .io_addr, .io_sel, .io_wr, .io_rd, .io_wdata, .io_rdata,
    .dsp_addr, .data_strobe, .io_space_strobe, .onboard_mem_sel, .board_mem_sel,
    .board_io_sel, .ext_addr, .wide_access_select, .odd_word_align, .board_half_sel,
    .ext_line_i, .ext_line_o, .ext_line_oe, .codec_clock_gate, .codec_power_enable,
    .left_input_select, .right_input_select, .deemphasis_select, .sample_speed_mode);
  dbc_dsp_model u_dsp (.mclk, .io_addr, .io_sel, .io_wr, .io_rd, .io_wdata, .io_rdata,
    .dsp_addr, .data_strobe, .io_space_strobe);
  initial begin
    forever #4 mclk = ~mclk;
  end
  task automatic stop_test;
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input logic [19:0] g, input logic [19:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string m);
    logic [7:0] d;
    u_dsp.rd(a, d);
    chk(20'(d), 20'(e), m);
  endtask : rchk
  task automatic t_reset;
    rchk(3'h2, 8'h80, "mem rst");
    rchk(3'h3, 8'h38, "line rst");
    rchk(3'h4, 8'h06, "codec rst");
    chk(20'({ext_line_oe, ext_line_o}), 20'h30, "line pins");
  endtask : t_reset
  task automatic t_lines;
    u_dsp.wr(3'h3, 8'hf5);
    chk(20'({ext_line_oe, ext_line_o}), 20'hf5, "drive");
    rchk(3'h3, 8'hf5, "drive rd");
    u_dsp.wr(3'h3, 8'h0f);
    ext_drv = 4'h6;
    chk(20'(ext_line_oe), 20'h0, "release");
    rchk(3'h3, 8'h06, "input rd");
  endtask : t_lines
  task automatic t_codec;
    logic [7:0] v;
    // Clocks on before the codec is enabled
    u_dsp.wr(3'h4, 8'h80);
    chk(20'({codec_clock_gate, codec_power_enable}), 20'h2, "clk on");
    for (int i = 0; i < 4; i++) begin
      v = {3'b111, i[0], ~i[0], 2'(i), i[0]} & 8'hdf;
      u_dsp.wr(3'h4, v | 8'h20);
      rchk(3'h4, v, "codec rd");
      chk(20'({codec_clock_gate, codec_power_enable, 1'b0, left_input_select,
        right_input_select, deemphasis_select, sample_speed_mode}), 20'(v), "codec");
    end
    // Power down first, clocks stopped afterwards
    u_dsp.wr(3'h4, 8'h80);
    u_dsp.wr(3'h4, 8'h00);
    chk(20'({codec_clock_gate, codec_power_enable}), 20'h0, "codec off");
  endtask : t_codec
  task automatic t_mem;
    u_dsp.wr(3'h2, 8'h45);
    rchk(3'h2, 8'h45, "mem rd");
    // Wide write pair at even base: upper half first, then lower half
    u_dsp.acc(16'h8001, 1'b0, 1'b1);
    chk(20'(board_half_sel), 20'h1, "wr upper");
    u_dsp.acc(16'h8000, 1'b0, 1'b1);
    chk(20'(board_half_sel), 20'h0, "wr lower");
    // Wide read pair: only the upper-half access at 0x8001 is driven and checked
    u_dsp.acc(16'h8001, 1'b0, 1'b1);
    chk(20'(board_half_sel), 20'h1, "rd upper");
    u_dsp.acc(16'h9234, 1'b1, 1'b0);
    chk(20'({onboard_mem_sel, board_mem_sel, wide_access_select, odd_word_align}),
      20'ha, "onboard");
    chk(ext_addr, 20'h29234, "page 5");
    u_dsp.acc(16'h1234, 1'b1, 1'b0);
    chk(20'(onboard_mem_sel), 20'h0, "below win");
    u_dsp.wr(3'h2, 8'hbf);
    u_dsp.acc(16'hffff, 1'b0, 1'b1);
    chk(20'({onboard_mem_sel, board_io_sel, wide_access_select, odd_word_align}),
      20'h5, "board io");
    chk(ext_addr, 20'hfffff, "page 31");
    u_dsp.acc(16'h8001, 1'b1, 1'b0);
    chk(20'({onboard_mem_sel, board_mem_sel}), 20'h1, "board mem");
    u_dsp.wr(3'h0, 8'hff);
    rchk(3'h0, 8'h00, "unmapped");
    rchk(3'h7, 8'h00, "unmapped 7");
    rchk(3'h2, 8'hbf, "mem kept");
  endtask : t_mem
  initial begin
    repeat (6) @(negedge mclk);
    arst_n = 1'b1;
    t_reset();
    t_lines();
    t_codec();
    t_mem();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
